//--- rtl/npe_pkg.sv
/*
  Shared constants for the program/erase control block: register offsets,
  control bit positions, alternate-space map, unlock keys, timing.
  Assumes an 8-bit register port and a 100 MHz system clock.
*/
package npe_pkg;
  // ==========================================
  // Register offsets (port address)
  localparam logic [2:0] ADDR_DATA_LOW = 3'h0;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h1;
  localparam logic [2:0] ADDR_ADDR_LOW = 3'h2;
  localparam logic [2:0] ADDR_ADDR_HIGH = 3'h3;
  localparam logic [2:0] ADDR_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_UNLOCK = 3'h5;
  // ==========================================
  // Control register bit positions
  localparam int BIT_READ = 0;
  localparam int BIT_LAUNCH = 1;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_FAULT = 3;
  localparam int BIT_ERASE = 4;
  localparam int BIT_LATCH_ONLY = 5;
  localparam int BIT_SPACE = 6;
  // ==========================================
  // Unlock keys and word layout
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int WORD_W = 14;
  localparam int ADDR_W = 15;
  localparam int LATCH_SEL_W = 5;
  localparam int LATCH_COUNT = 32;
  localparam logic [13:0] BLANK_WORD = 14'h3fff;
  localparam logic [6:0] ADDR_HIGH_RESERVED = 7'h00;
  // ==========================================
  // Alternate-space map (addresses with the space bit as bit 15)
  localparam logic [15:0] UID_LO = 16'h8000;
  localparam logic [15:0] UID_HI = 16'h8003;
  localparam logic [15:0] ID_LO = 16'h8005;
  localparam logic [15:0] ID_HI = 16'h8006;
  localparam logic [15:0] CFG_LO = 16'h8007;
  localparam logic [15:0] CFG_HI = 16'h800b;
  localparam logic [15:0] EE_LO = 16'hf000;
  localparam logic [15:0] EE_HI = 16'hf0ff;
  // ==========================================
  // Self-timed operation length
  localparam int CLK_MHZ = 100;
  localparam int OP_TIME_US = 2;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  // ==========================================
  // Kinds of access presented to the memory
  typedef enum logic [2:0] {
    NPE_OP_NONE,
    NPE_OP_READ,
    NPE_OP_ERASE_ROW,
    NPE_OP_WRITE_ROW,
    NPE_OP_WRITE_ALT
  } npe_op_t;
endpackage

//--- rtl/npe_alt_map.sv
/*
  Decodes an alternate-space address into read and write permission.
  Purely combinational; assumes a 16-bit address with the space bit on top.
*/
`timescale 1ns/10ps
module npe_alt_map
  import npe_pkg::*;
(
  input wire logic [15:0] altAddr,
  output logic readOk,
  output logic writeOk
);
  wire inUid = (altAddr >= UID_LO) && (altAddr <= UID_HI);
  wire inId = (altAddr >= ID_LO) && (altAddr <= ID_HI);
  wire inCfg = (altAddr >= CFG_LO) && (altAddr <= CFG_HI);
  wire inEe = (altAddr >= EE_LO) && (altAddr <= EE_HI);
  assign readOk = inUid | inId | inCfg | inEe;
  assign writeOk = inUid | inEe;
endmodule

//--- rtl/npe_latches.sv
/*
  Row write latches: one word per slot, blank after every row operation.
  Assumes the controller issues at most one load or clear per cycle.
*/
`timescale 1ns/10ps
module npe_latches
  import npe_pkg::*;
#(
  parameter int COUNT = LATCH_COUNT,
  parameter int SEL_W = LATCH_SEL_W
)
(
  input wire logic mclk,
  input wire logic rstSyncB,
  input wire logic loadEn,
  input wire logic [SEL_W-1:0] loadSel,
  input wire logic [WORD_W-1:0] loadWord,
  input wire logic clearAll,
  output logic [COUNT*WORD_W-1:0] rowData
);
  genvar g;
  generate
    for (g = 0; g < COUNT; g++)
    begin : gSlot
      logic [WORD_W-1:0] word_q;
      wire hit = loadEn && (loadSel == SEL_W'(g));
      always_ff @(posedge mclk or negedge rstSyncB)
      begin
        if (!rstSyncB)
          word_q <= BLANK_WORD;
        else if (clearAll)
          word_q <= BLANK_WORD;
        else if (hit)
          word_q <= loadWord;
      end
      assign rowData[g*WORD_W +: WORD_W] = word_q;
    end
  endgenerate
endmodule

//--- rtl/npe_control.sv
/*
  Program/erase command logic: register port, unlock check, launch decode,
  write-protect and fault flagging, alternate-space map, memory access port.
  Assumes a synchronous 8-bit register master and a flash macro that answers
  reads in the same cycle and needs only the row request for writes.
*/
`timescale 1ns/10ps
// Behaviour
// - space bit selects alternate space
// - bad alternate read returns zeros
// - alternate reads wide, writes UID/EEPROM only
// - ident range readable, write refused
// - erase or row-program launch on protected address sets fault
// - reset during operation sets fault; the code loads fault from faultAtReset after reset
// - broken unlock sets fault, no launch
// - fault settable by software, never hardware-cleared
// - erase-select erases whole 32-word row
// - protected row operation aborted with fault
// - latch-only launch loads one latch
// - latch load ignores write protect
// - plain launch programs latches into row
// - data-low register readable and writable
// - 55h then AAh before launch
// - self-timed, launch cleared when done
// - latches blank after row write or erase
// - low five address bits pick latch
module npe_control
  import npe_pkg::*;
#(
  parameter int OP_LEN = OP_CYCLES
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic [ADDR_W-1:0] protectBase,
  input wire logic faultAtReset,
  output npe_pkg::npe_op_t memOp,
  output logic [15:0] memAddr,
  output logic [WORD_W-1:0] memWdata,
  output logic [LATCH_COUNT*WORD_W-1:0] memRow,
  input wire logic [WORD_W-1:0] memRdata,
  output logic busy
);
  import npe_pkg::*;

  // ==========================================
  // Reset release
  logic rstMeta_q, rstSyncB;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_q <= 1'b0;
      rstSyncB <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSyncB <= rstMeta_q;
    end
  end

  typedef enum logic [1:0] {NPE_IDLE, NPE_KEY1, NPE_ARMED} npe_key_t;
  typedef enum logic {NPE_READY, NPE_RUN} npe_run_t;

  logic [7:0] dataLow_q, dataLow_d;
  logic [5:0] dataHigh_q, dataHigh_d;
  logic [7:0] addrLow_q;
  logic [6:0] addrHigh_q;
  logic space_q, latchOnly_q, erase_q, permit_q, fault_q, fault_d, launch_q;
  logic read_q;
  npe_key_t key_q, key_d;
  npe_run_t run_q, run_d;
  logic [$clog2(OP_LEN+1)-1:0] cnt_q;
  logic captured_q;
  npe_op_t memOp_q;

  // ==========================================
  // Decode
  wire wrData = regWrite && (regAddr == ADDR_DATA_LOW);
  wire wrDataH = regWrite && (regAddr == ADDR_DATA_HIGH);
  wire wrAddrL = regWrite && (regAddr == ADDR_ADDR_LOW);
  wire wrAddrH = regWrite && (regAddr == ADDR_ADDR_HIGH);
  wire wrCtl = regWrite && (regAddr == ADDR_CONTROL);
  wire wrKey = regWrite && (regAddr == ADDR_UNLOCK);
  wire [ADDR_W-1:0] fullAddr = {addrHigh_q, addrLow_q};
  // space bit picks the alternate map
  wire [15:0] targetAddr = {space_q, fullAddr};
  wire altRead, altWrite;
  npe_alt_map uMap (
    .altAddr(targetAddr),
    .readOk(altRead),
    .writeOk(altWrite)
  );
  wire pfmProtected = !space_q && (fullAddr < protectBase);
  wire launchReq = wrCtl && regWdata[BIT_LAUNCH] && !launch_q;
  // launch valid only as the next port access after both keys
  wire unlocked = (key_q == NPE_ARMED);
  wire goodLaunch = launchReq && unlocked && permit_q;
  // launch without the full key sequence
  wire badKey = launchReq && !unlocked && permit_q;
  wire isErase = !space_q && erase_q;
  wire isLoad = !space_q && !erase_q && latchOnly_q;
  wire isRow = !space_q && !erase_q && !latchOnly_q;
  // row operations to protected area aborted
  // latch loads skip the protect check
  wire protHit = goodLaunch &&
    ((space_q && !altWrite) || ((isErase || isRow) && pfmProtected));
  wire startOp = goodLaunch && !protHit && !isLoad;
  wire loadNow = goodLaunch && isLoad;
  wire readReq = wrCtl && regWdata[BIT_READ] && !busy;
  wire opDone = (run_q == NPE_RUN) && (cnt_q == 0);

  // ==========================================
  // Unlock sequencer
  always_comb
  begin
    key_d = NPE_IDLE;
    unique case (key_q)
      NPE_IDLE: key_d = (wrKey && regWdata == KEY_FIRST) ? NPE_KEY1 : NPE_IDLE;
      NPE_KEY1: key_d = (wrKey && regWdata == KEY_SECOND) ? NPE_ARMED : NPE_IDLE;
      NPE_ARMED: key_d = NPE_IDLE;
    endcase
    // Any other write between keys breaks the sequence
    if (key_q == NPE_IDLE && wrKey && regWdata == KEY_FIRST)
      key_d = NPE_KEY1;
    else if (key_q == NPE_ARMED && !regWrite && !regRead)
      key_d = NPE_ARMED;
  end

  // ==========================================
  // Run timer
  always_comb
  begin
    run_d = run_q;
    if (startOp)
      run_d = NPE_RUN;
    else if (opDone)
      run_d = NPE_READY;
  end

  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      key_q <= NPE_IDLE;
      run_q <= NPE_READY;
    end
    else
    begin
      key_q <= key_d;
      run_q <= run_d;
    end
  end

  // self-timed count, launch bit drops at end
  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
      cnt_q <= '0;
    else if (startOp)
      cnt_q <= ($clog2(OP_LEN+1))'(OP_LEN - 1);
    else if (cnt_q != 0)
      cnt_q <= cnt_q - 1'b1;
  end

  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
      launch_q <= 1'b0;
    else if (startOp)
      launch_q <= 1'b1;
    else if (opDone)
      launch_q <= 1'b0;
  end
  assign busy = launch_q;

  // ==========================================
  // Fault flag: hardware only sets it
  always_comb
  begin
    fault_d = fault_q;
    if (wrCtl)
      fault_d = regWdata[BIT_FAULT];
    // software may write it; set still wins
    if (protHit || badKey)
      fault_d = 1'b1;
  end

  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      captured_q <= 1'b0;
      fault_q <= 1'b0;
    end
    else if (!captured_q)
    begin
      captured_q <= 1'b1;
      fault_q <= faultAtReset | fault_d;
    end
    else
      fault_q <= fault_d;
  end

  // ==========================================
  // Control bits
  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      space_q <= 1'b0;
      latchOnly_q <= 1'b0;
      erase_q <= 1'b0;
      permit_q <= 1'b0;
      read_q <= 1'b0;
    end
    else
    begin
      read_q <= readReq;
      if (wrCtl)
      begin
        space_q <= regWdata[BIT_SPACE];
        latchOnly_q <= regWdata[BIT_LATCH_ONLY];
        permit_q <= regWdata[BIT_PERMIT];
        if (!busy)
          erase_q <= regWdata[BIT_ERASE];
      end
      else if (opDone)
        erase_q <= 1'b0;
    end
  end

  // ==========================================
  // Address registers
  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      addrLow_q <= 8'h00;
      addrHigh_q <= ADDR_HIGH_RESERVED;
    end
    else
    begin
      if (wrAddrL && !busy)
        addrLow_q <= regWdata;
      if (wrAddrH && !busy)
        addrHigh_q <= regWdata[6:0];
    end
  end

  // ==========================================
  // Data registers and read path
  always_comb
  begin
    dataLow_d = dataLow_q;
    dataHigh_d = dataHigh_q;
    if (wrData)
      dataLow_d = regWdata;
    if (wrDataH)
      dataHigh_d = regWdata[5:0];
    if (read_q)
    begin
      if (space_q && !altRead)
      begin
        dataLow_d = 8'h00;
        dataHigh_d = 6'h00;
      end
      else
      begin
        dataLow_d = memRdata[7:0];
        dataHigh_d = memRdata[13:8];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
    begin
      dataLow_q <= 8'h00;
      dataHigh_q <= 6'h00;
    end
    else
    begin
      dataLow_q <= dataLow_d;
      dataHigh_q <= dataHigh_d;
    end
  end

  // ==========================================
  // Write latches
  npe_latches #(
    .COUNT(LATCH_COUNT),
    .SEL_W(LATCH_SEL_W)
  ) uLatch (
    .mclk(mclk),
    .rstSyncB(rstSyncB),
    .loadEn(loadNow),
    .loadSel(addrLow_q[LATCH_SEL_W-1:0]),
    .loadWord({dataHigh_q, dataLow_q}),
    .clearAll(opDone && !space_q),
    .rowData(memRow)
  );

  // ==========================================
  // Memory request
  npe_op_t opSel;
  assign opSel = space_q ? NPE_OP_WRITE_ALT : (isErase ? NPE_OP_ERASE_ROW : NPE_OP_WRITE_ROW);

  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
      memOp_q <= NPE_OP_NONE;
    else if (startOp)
      memOp_q <= opSel;
    else if (readReq)
      memOp_q <= NPE_OP_READ;
    else
      memOp_q <= NPE_OP_NONE;
  end
  assign memOp = memOp_q;
  // row boundary from the upper address bits
  assign memAddr = (memOp_q == NPE_OP_ERASE_ROW || memOp_q == NPE_OP_WRITE_ROW) ?
    {space_q, fullAddr[ADDR_W-1:LATCH_SEL_W], {LATCH_SEL_W{1'b0}}} : targetAddr;
  assign memWdata = {dataHigh_q, dataLow_q};

  // ==========================================
  // Read data, one cycle after strobe
  wire [7:0] ctlView = {1'b0, space_q, latchOnly_q, erase_q, fault_q, permit_q,
    launch_q, read_q};
  logic [7:0] rdSel;
  always_comb
  begin
    rdSel = 8'h00;
    unique case (regAddr)
      ADDR_DATA_LOW: rdSel = dataLow_q;
      ADDR_DATA_HIGH: rdSel = {2'b00, dataHigh_q};
      ADDR_ADDR_LOW: rdSel = addrLow_q;
      ADDR_ADDR_HIGH: rdSel = {1'b1, addrHigh_q};
      ADDR_CONTROL: rdSel = ctlView;
      default: rdSel = 8'h00;
    endcase
  end
  always_ff @(posedge mclk or negedge rstSyncB)
  begin
    if (!rstSyncB)
      regRdata <= 8'h00;
    else
      regRdata <= regRead ? rdSel : 8'h00;
  end

  // ==========================================
  // Checks
  AST_NOKEY: assert property (@(posedge mclk) disable iff (!rstSyncB)
    badKey |=> fault_q && !launch_q)
    else $error("broken unlock did not fault");
  AST_PROT: assert property (@(posedge mclk) disable iff (!rstSyncB)
    protHit |=> fault_q && memOp == NPE_OP_NONE)
    else $error("protected launch not refused");
  AST_DONE: assert property (@(posedge mclk) disable iff (!rstSyncB)
    $fell(launch_q) |-> $past(cnt_q) == 0)
    else $error("launch dropped early");
  AST_PERMIT: assert property (@(posedge mclk) disable iff (!rstSyncB)
    (launchReq && !permit_q && !launch_q) |=> !launch_q)
    else $error("launch without permit");
  AST_ZERO: assert property (@(posedge mclk) disable iff (!rstSyncB)
    (read_q && space_q && !altRead) |=> dataLow_q == 8'h00 && dataHigh_q == 6'h00)
    else $error("unmapped read not zero");
  AST_IDRO: assert property (@(posedge mclk) disable iff (!rstSyncB)
    (goodLaunch && space_q && targetAddr == ID_LO) |=> fault_q && !launch_q)
    else $error("ident write not refused");
  AST_STICKY: assert property (@(posedge mclk) disable iff (!rstSyncB)
    (fault_q && !wrCtl) |=> fault_q)
    else $error("fault cleared by hardware");
  AST_ERASE: assert property (@(posedge mclk) disable iff (!rstSyncB)
    (startOp && isErase) |=> memOp == NPE_OP_ERASE_ROW && memAddr[4:0] == 5'h00)
    else $error("erase not row aligned");
  AST_DATA: assert property (@(posedge mclk) disable iff (!rstSyncB)
    (wrData && !read_q) |=> dataLow_q == $past(regWdata))
    else $error("data low not stored");
  COV_LOAD: cover property (@(posedge mclk) disable iff (!rstSyncB) loadNow);
  COV_ROW: cover property (@(posedge mclk) disable iff (!rstSyncB) startOp && isRow);
  COV_ERASE: cover property (@(posedge mclk) disable iff (!rstSyncB) opDone && erase_q);
endmodule

//--- testbench/npe_control_bench.sv
/*
  Self-checking bench for the program/erase control block: register port
  tasks, unlock and launch sequences, checks on the memory access port.
  Assumes the bench stands in for the flash macro and answers reads in time.
*/
`timescale 1ns/10ps
module npe_control_bench;
  import npe_pkg::*;
  localparam int OPL = 4;
  // Bit 16 marks a readable (in WR_TAB a writable) place, bit 15 the alternate space
  localparam logic [16:0] RD_TAB [11] = '{17'h10123, 17'h18000, 17'h18003, 17'h08004,
    17'h18005, 17'h18006, 17'h1800b, 17'h0800c, 17'h1f000, 17'h1f0ff, 17'h0f100};
  localparam logic [16:0] WR_TAB [5] = '{17'h18000, 17'h18003, 17'h08005, 17'h08007,
    17'h1f0ff};
  logic mclk;
  logic rst_b;
  logic [2:0] regAddr;
  logic [7:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [7:0] regRdata;
  logic [ADDR_W-1:0] protectBase;
  logic faultAtReset;
  npe_op_t memOp;
  logic [15:0] memAddr;
  logic [WORD_W-1:0] memWdata;
  logic [LATCH_COUNT*WORD_W-1:0] memRow;
  logic [WORD_W-1:0] memRdata;
  logic busy;
  int mismatches;
  int check_count;
  int opCount;
  int n0;
  npe_op_t lastOp;
  logic [15:0] opAddr;
  logic [WORD_W-1:0] opData;
  logic [LATCH_COUNT*WORD_W-1:0] opRow;
  logic [7:0] v;
  logic [13:0] w;
  logic [16:0] e;

  npe_control #(.OP_LEN(OPL)) dut (
    .mclk(mclk),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .protectBase(protectBase),
    .faultAtReset(faultAtReset),
    .memOp(memOp),
    .memAddr(memAddr),
    .memWdata(memWdata),
    .memRow(memRow),
    .memRdata(memRdata),
    .busy(busy)
  );

  // ==========================================
  // Clock, flash stand-in, access monitor
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Read word is a known scramble of the address, valid in the request cycle
  assign memRdata = memAddr[13:0] ^ 14'h1234;

  always @(posedge mclk)
  begin
    if (memOp !== NPE_OP_NONE)
    begin
      opCount = opCount + 1;
      lastOp = memOp;
      opAddr = memAddr;
      opData = memWdata;
      opRow = memRow;
    end
  end

  // ==========================================
  // Port tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  // Strobe left high so writes may run back to back
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regWrite <= 1'b1;
    regRead <= 1'b0;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    @(posedge mclk);
    d = regRdata;
  endtask

  task automatic setAddr(input logic [14:0] a);
    wr(ADDR_ADDR_LOW, a[7:0]);
    wr(ADDR_ADDR_HIGH, {1'b0, a[14:8]});
  endtask

  task automatic launch(input logic [7:0] ctl);
    n0 = opCount;
    // Modes settle first; the launch decode uses the stored bits
    wr(ADDR_CONTROL, ctl & 8'hfd);
    wr(ADDR_UNLOCK, KEY_FIRST);
    wr(ADDR_UNLOCK, KEY_SECOND);
    wr(ADDR_CONTROL, ctl);
    idle(3);
  endtask

  task automatic fault(input logic exp);
    rd(ADDR_CONTROL, v);
    check(v[BIT_FAULT], exp, "fault flag");
  endtask

  task automatic waitIdle();
    for (int i = 0; i < OPL + 4 && busy !== 1'b0; i++) @(posedge mclk);
    check(busy, 1'b0, "busy end");
    idle(1);
  endtask

  task automatic note(input string s);
    $display("test %s finished", s);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #100us;
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ==========================================
  // Tests
  initial
  begin
    rst_b = 1'b0;
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    protectBase = 15'h0100;
    faultAtReset = 1'b0;
    mismatches = 0;
    check_count = 0;
    opCount = 0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    idle(3);
    wr(ADDR_DATA_LOW, 8'ha5);
    rd(ADDR_DATA_LOW, v);
    check(v, 8'ha5, "data low");
    wr(ADDR_DATA_LOW, 8'h5a);
    rd(ADDR_DATA_LOW, v);
    check(v, 8'h5a, "data low");
    note("data register");
    foreach (RD_TAB[i])
    begin
      e = RD_TAB[i];
      setAddr(e[14:0]);
      wr(ADDR_DATA_LOW, 8'hff);
      wr(ADDR_DATA_HIGH, 8'h3f);
      wr(ADDR_CONTROL, e[15] ? 8'h41 : 8'h01);
      idle(3);
      w = e[16] ? (e[13:0] ^ 14'h1234) : 14'h0000;
      rd(ADDR_DATA_LOW, v);
      check(v, w[7:0], "read low");
      if (!e[15] || !e[16])
      begin
        rd(ADDR_DATA_HIGH, v);
        check(v, {2'b00, w[13:8]}, "read high");
      end
    end
    note("reads");
    wr(ADDR_DATA_LOW, 8'h11);
    wr(ADDR_DATA_HIGH, 8'h15);
    foreach (WR_TAB[i])
    begin
      e = WR_TAB[i];
      wr(ADDR_CONTROL, 8'h00);
      setAddr(e[14:0]);
      launch(8'h46);
      check(opCount - n0, e[16], "alt ops");
      fault(!e[16]);
      if (e[16])
      begin
        check(lastOp, NPE_OP_WRITE_ALT, "alt kind");
        check(opAddr, e[15:0], "alt addr");
        check(opData, 14'h1511, "alt data");
      end
      waitIdle();
    end
    note("alternate writes");
    wr(ADDR_CONTROL, 8'h00);
    setAddr(15'h0123);
    for (int i = 0; i < 3; i++)
    begin
      launch(i == 0 ? 8'h02 : (i == 1 ? 8'h22 : 8'h12));
      check(opCount - n0, 0, "no permit op");
      check(memRow[14*3+:14], BLANK_WORD, "no permit latch");
      fault(1'b0);
    end
    note("permit");
    wr(ADDR_DATA_HIGH, 8'h3c);
    for (int i = 0; i < 2; i++)
    begin
      n0 = opCount;
      wr(ADDR_CONTROL, 8'h24);
      wr(ADDR_UNLOCK, i == 0 ? KEY_FIRST : KEY_SECOND);
      if (i == 0)
        wr(ADDR_DATA_LOW, 8'h5a);
      wr(ADDR_UNLOCK, i == 0 ? KEY_SECOND : KEY_FIRST);
      wr(ADDR_CONTROL, 8'h26);
      idle(3);
      check(opCount - n0, 0, "broken unlock op");
      check(memRow[14*3+:14], BLANK_WORD, "broken unlock latch");
      fault(1'b1);
    end
    note("unlock");
    wr(ADDR_CONTROL, 8'h00);
    setAddr(15'h0045);
    launch(8'h26);
    check(memRow[14*5+:14], 14'h3c5a, "latch load");
    check(opCount - n0, 0, "latch op");
    check(busy, 1'b0, "latch busy");
    fault(1'b0);
    foreach (RD_TAB[i])
    begin
      if (i < 2)
      begin
        launch(i == 0 ? 8'h06 : 8'h16);
        check(opCount - n0, 0, "protected op");
        check(busy, 1'b0, "protected busy");
        fault(1'b1);
        wr(ADDR_CONTROL, 8'h00);
      end
    end
    note("protect");
    setAddr(15'h0123);
    wr(ADDR_DATA_LOW, 8'h77);
    wr(ADDR_DATA_HIGH, 8'h0a);
    launch(8'h26);
    launch(8'h06);
    check(opCount - n0, 1, "row op");
    check(lastOp, NPE_OP_WRITE_ROW, "row kind");
    check(opAddr, 16'h0120, "row addr");
    check(opRow[14*3+:14], 14'h0a77, "row latch 3");
    check(opRow[14*5+:14], 14'h3c5a, "row latch 5");
    check(busy, 1'b1, "row busy");
    waitIdle();
    check(memRow === {LATCH_COUNT{BLANK_WORD}}, 1'b1, "blank after write");
    setAddr(15'h0121);
    launch(8'h26);
    launch(8'h36);
    check(lastOp, NPE_OP_ERASE_ROW, "erase kind");
    check(opAddr, 16'h0120, "erase addr");
    check(opCount - n0, 1, "erase op");
    waitIdle();
    check(memRow === {LATCH_COUNT{BLANK_WORD}}, 1'b1, "blank after erase");
    // rewrite: erased row, reload latch, program
    launch(8'h26);
    launch(8'h06);
    check(opCount - n0, 1, "rewrite op");
    check(opRow[14*1+:14], 14'h0a77, "rewrite latch 1");
    waitIdle();
    // read back after the last write
    wr(ADDR_CONTROL, 8'h01);
    idle(3);
    w = 14'h0121 ^ 14'h1234;
    rd(ADDR_DATA_LOW, v);
    check(v, w[7:0], "verify low");
    rd(ADDR_DATA_HIGH, v);
    check(v, {2'b00, w[13:8]}, "verify high");
    fault(1'b0);
    note("row operations");
    wr(ADDR_CONTROL, 8'h08);
    idle(10);
    fault(1'b1);
    wr(ADDR_CONTROL, 8'h00);
    fault(1'b0);
    for (int i = 1; i >= 0; i--)
    begin
      rst_b <= 1'b0;
      faultAtReset <= i[0];
      idle(5);
      rst_b <= 1'b1;
      idle(4);
      faultAtReset <= 1'b0;
      fault(i[0]);
    end
    note("fault flag");
    tally_and_finish();
  end
endmodule
